// *** include/disp_setup_consts.vh ***
// command codes, parameter field positions, reset values and timing counts for the display setup block
// included by hw/ design files; definitions only
`ifndef DISP_SETUP_CONSTS_VH
`define DISP_SETUP_CONSTS_VH

`define CMD_DISPLAY_SETUP 8'hb2
`define CMD_PIXEL_IF_POL 8'hb3
`define CMD_EXT_UNLOCK 8'hb9
`define CMD_DISPLAY_ON 8'h29
`define CMD_DISPLAY_OFF 8'h28
`define CMD_SLEEP_IN 8'h10
`define CMD_SLEEP_OUT 8'h11
`define CMD_SOFT_RESET 8'h01
`define UNLOCK_KEY0 8'hff
`define UNLOCK_KEY1 8'h83
`define UNLOCK_KEY2 8'h92

`define SETUP_PARAM_COUNT 4'hc
`define PAR_SRCGATE 4'h0
`define PAR_LINES 4'h1
`define PAR_BPORCH 4'h2
`define PAR_FPORCH 4'h3
`define PAR_LPERIOD 4'h4
`define PAR_OPAMP 4'h5
`define PAR_GAMMA_AMP_ON_TIME 4'h6
`define PAR_GAMMA_AMP_OFF_TIME 4'h7
`define PAR_BPORCH_PI 4'h8
`define PAR_FPORCH_PI 4'h9
`define PAR_LPERIOD_PI 4'ha
`define PAR_RES_SW 4'hb

`define SRC_GROUND 2'h0
`define SRC_FULL_SCALE 2'h2
`define SRC_DISPLAY 2'h3

`define RST_SRCGATE 8'h08
`define RST_LINES 8'hc8
`define RST_PORCH 8'h00
`define RST_LPERIOD 8'h05
`define RST_OPAMP 8'h70
`define RST_GAMMA_AMP_ON_TIME 8'h00
`define RST_GAMMA_AMP_OFF_TIME 8'hff
`define RST_RES_SW 8'h20
`define RST_POLARITY 4'h1

`define LINE_BASE 11'd480
`define LPERIOD_BASE 11'd600
`define PORCH_ADD 9'd2
`define NL_MAX 8'hde
`define OSC_HZ 40000000
`define INIT_STEP_MS 1
`define INIT_STEP_CYCLES (`OSC_HZ / 1000 * `INIT_STEP_MS)

`endif

// *** hw/param_store.v ***
// twelve-byte parameter memory with registered read-out of every entry
// written from the command decoder on mclk; reset loads the defaults
`timescale 1ns/10ps
`include "disp_setup_consts.vh"

module param_store #(
  parameter DEPTH = 12
) (
  input wire mclk,
  input wire reset,
  input wire wr_en,
  input wire [3:0] wr_idx,
  input wire [7:0] wr_data,
  input wire [1:0] src_force,
  input wire src_force_en,
  input wire [1:0] gate_force,
  input wire gate_force_en,
  output wire [DEPTH*8-1:0] rd_flat
);
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : entry
      reg [7:0] mem_reg;
      wire [7:0] rst_val;
      assign rst_val = (i == `PAR_SRCGATE) ? `RST_SRCGATE :
                       (i == `PAR_LINES) ? `RST_LINES :
                       (i == `PAR_LPERIOD || i == `PAR_LPERIOD_PI) ? `RST_LPERIOD :
                       (i == `PAR_OPAMP) ? `RST_OPAMP :
                       (i == `PAR_GAMMA_AMP_OFF_TIME) ? `RST_GAMMA_AMP_OFF_TIME :
                       (i == `PAR_RES_SW) ? `RST_RES_SW : `RST_PORCH;
      always @(posedge mclk) begin
        if (reset) begin
          mem_reg <= rst_val;
        end else if (i == `PAR_SRCGATE && (src_force_en || gate_force_en)) begin
          mem_reg[1:0] <= src_force_en ? src_force : mem_reg[1:0];
          mem_reg[3:2] <= gate_force_en ? gate_force : mem_reg[3:2];
        end else if (wr_en && wr_idx == i) begin
          mem_reg <= wr_data;
        end
      end
      assign rd_flat[i*8 +: 8] = mem_reg;
    end
  endgenerate
endmodule // param_store

// *** hw/display_setup.v ***
// display setup command decoder: parameter bytes, auto source/gate control, pixel input polarity
// command bytes arrive on mclk from the link decoder; pixel pins are asynchronous
//
// Operation
// - setup opcode then twelve parameter bytes accepted
// - two-bit source field selects ground, full, display
// - display on sets 11, off sets 10
// - sleep in: source 00, gate pair 10
// - sleep out: gate pair 11
// - gate off, low only, or full swing
// - porch lines equal value plus two
// - partial idle uses its own porch fields
// - opamp current is field plus one times reference
// - init pulse one to five ms, others inhibited
// - clocks per line 600 plus four times field
// - driven lines 480 plus four times field
// - line count leaves memory mapping unchanged
// - switch order selects one of four sequences
// - resolution disables central source band
// - all resets load the default values
// - setup commands need extended unlock first
// - polarity byte: edge, hsync, vsync, enable
// - display enabled when enable matches polarity
// - sync active level follows polarity bit
// - pixel edge select rising or falling
`timescale 1ns/10ps
`include "disp_setup_consts.vh"

module display_setup #(
  parameter INIT_STEP = `INIT_STEP_CYCLES
) (
  input wire mclk,
  input wire reset,
  input wire cmd_valid,
  input wire cmd_is_param,
  input wire [7:0] cmd_byte,
  input wire partial_idle,
  input wire pixel_clock_in,
  input wire vertical_sync_in,
  input wire horizontal_sync_in,
  input wire enable_in,
  input wire init_start,
  output reg [1:0] source_mode,
  output reg gate_low_drive,
  output reg gate_high_drive,
  output reg [8:0] porch_front_lines,
  output reg [8:0] porch_back_lines,
  output reg [10:0] line_clocks,
  output reg [10:0] driven_lines,
  output reg [4:0] opamp_current_mult,
  output reg [1:0] switch_order_sel,
  output reg [2:0] resolution_sel,
  output reg [9:0] band_first,
  output reg [9:0] band_last,
  output reg band_off,
  output reg [7:0] gamma_amp_on_time,
  output reg [7:0] gamma_amp_off_time,
  output reg init_pulse,
  output reg display_enabled,
  output reg vsync_active,
  output reg hsync_active,
  output reg pixel_sample,
  output reg ext_unlocked
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SETUP = 2'd1;
  localparam ST_POL = 2'd2;
  localparam ST_UNLOCK = 2'd3;

  reg [1:0] state_reg, state_next;
  reg [3:0] idx_reg, idx_next;
  reg unlock_reg, unlock_next;
  reg [3:0] polarity_reg;
  // pin synchronisers: {pixel clock, hsync, vsync} and enable
  reg [2:0] sync1_reg, sync2_reg;
  reg en1_reg, en2_reg;
  reg pclk_prev_reg;
  reg [2:0] init_steps_reg;
  reg [31:0] init_cnt_reg;
  reg init_run_reg;
  reg wr_en;
  reg [1:0] src_force;
  reg src_force_en;
  reg [1:0] gate_force;
  reg gate_force_en;
  reg soft_rst;
  wire store_rst;
  wire [95:0] pf;
  wire [7:0] p_srcgate, p_lines, p_bp, p_fp, p_lp, p_op, p_bpi, p_fpi, p_lpi, p_res;
  wire cmd_cmd, cmd_par;

  assign cmd_cmd = cmd_valid && !cmd_is_param;
  assign cmd_par = cmd_valid && cmd_is_param;
  // software reset reloads parameter and polarity defaults; the unlock survives it
  assign store_rst = reset | soft_rst;

  // forces from display and sleep commands win over byte-zero writes
  param_store #(
    .DEPTH(12)
  ) store (
    .mclk(mclk),
    .reset(store_rst),
    .wr_en(wr_en),
    .wr_idx(idx_reg),
    .wr_data(cmd_byte),
    .src_force(src_force),
    .src_force_en(src_force_en),
    .gate_force(gate_force),
    .gate_force_en(gate_force_en),
    .rd_flat(pf)
  );

  assign p_srcgate = pf[`PAR_SRCGATE*8 +: 8];
  assign p_lines = pf[`PAR_LINES*8 +: 8];
  assign p_bp = pf[`PAR_BPORCH*8 +: 8];
  assign p_fp = pf[`PAR_FPORCH*8 +: 8];
  assign p_lp = pf[`PAR_LPERIOD*8 +: 8];
  assign p_op = pf[`PAR_OPAMP*8 +: 8];
  assign p_bpi = pf[`PAR_BPORCH_PI*8 +: 8];
  assign p_fpi = pf[`PAR_FPORCH_PI*8 +: 8];
  assign p_lpi = pf[`PAR_LPERIOD_PI*8 +: 8];
  assign p_res = pf[`PAR_RES_SW*8 +: 8];

  // command sequencing
  always @* begin
    state_next = state_reg;
    idx_next = idx_reg;
    unlock_next = unlock_reg;
    wr_en = 1'b0;
    src_force = 2'b00;
    src_force_en = 1'b0;
    gate_force = 2'b00;
    gate_force_en = 1'b0;
    soft_rst = 1'b0;
    if (cmd_cmd) begin
      idx_next = 4'h0;
      state_next = ST_IDLE;
      case (cmd_byte)
        `CMD_EXT_UNLOCK: begin
          state_next = ST_UNLOCK;
          unlock_next = 1'b0;
        end
        `CMD_DISPLAY_SETUP: begin
          if (unlock_reg) begin
            state_next = ST_SETUP;
          end
        end
        `CMD_PIXEL_IF_POL: begin
          if (unlock_reg) begin
            state_next = ST_POL;
          end
        end
        `CMD_SOFT_RESET: begin
          soft_rst = 1'b1;
        end
        `CMD_DISPLAY_ON: begin
          src_force = `SRC_DISPLAY;
          src_force_en = 1'b1;
        end
        `CMD_DISPLAY_OFF: begin
          src_force = `SRC_FULL_SCALE;
          src_force_en = 1'b1;
        end
        `CMD_SLEEP_IN: begin
          src_force = `SRC_GROUND;
          src_force_en = 1'b1;
          gate_force = 2'b10;
          gate_force_en = 1'b1;
        end
        `CMD_SLEEP_OUT: begin
          gate_force = 2'b11;
          gate_force_en = 1'b1;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end else if (cmd_par) begin
      case (state_reg)
        // bytes past the twelfth arrive in idle and are dropped
        ST_SETUP: begin
          wr_en = 1'b1;
          idx_next = idx_reg + 4'h1;
          if (idx_reg == `SETUP_PARAM_COUNT - 4'h1) begin
            state_next = ST_IDLE;
          end
        end
        ST_POL: begin
          state_next = ST_IDLE;
        end
        // key bytes checked in order; any miss drops to idle still locked
        ST_UNLOCK: begin
          idx_next = idx_reg + 4'h1;
          if ((idx_reg == 4'h0 && cmd_byte != `UNLOCK_KEY0) || (idx_reg == 4'h1 && cmd_byte != `UNLOCK_KEY1)) begin
            state_next = ST_IDLE;
          end else if (idx_reg == 4'h2) begin
            unlock_next = (cmd_byte == `UNLOCK_KEY2);
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      idx_reg <= 4'h0;
      unlock_reg <= 1'b0;
      polarity_reg <= `RST_POLARITY;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      unlock_reg <= unlock_next;
      if (soft_rst) begin
        polarity_reg <= `RST_POLARITY;
      end else if (cmd_par && state_reg == ST_POL) begin
        polarity_reg <= cmd_byte[3:0];
      end
    end
  end

  // pixel pins through two flops
  always @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= 3'b000;
      sync2_reg <= 3'b000;
      en1_reg <= 1'b0;
      en2_reg <= 1'b0;
      pclk_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {pixel_clock_in, horizontal_sync_in, vertical_sync_in};
      sync2_reg <= sync1_reg;
      en1_reg <= enable_in;
      en2_reg <= en1_reg;
      pclk_prev_reg <= sync2_reg[2];
    end
  end

  // init pulse, one ms per step beyond the first
  // inhibited codes never start a pulse; any reset stops a running one
  always @(posedge mclk) begin
    if (reset || soft_rst) begin
      init_run_reg <= 1'b0;
      init_cnt_reg <= 32'h0;
      init_steps_reg <= 3'h0;
    end else if (init_start && p_op[2:0] <= 3'h4) begin
      init_run_reg <= 1'b1;
      init_cnt_reg <= INIT_STEP - 1;
      init_steps_reg <= p_op[2:0];
    end else if (init_run_reg) begin
      if (init_cnt_reg != 32'h0) begin
        init_cnt_reg <= init_cnt_reg - 32'h1;
      end else if (init_steps_reg != 3'h0) begin
        init_steps_reg <= init_steps_reg - 3'h1;
        init_cnt_reg <= INIT_STEP - 1;
      end else begin
        init_run_reg <= 1'b0;
      end
    end
  end

  // decoded outputs, all registered
  always @(posedge mclk) begin
    if (reset) begin
      source_mode <= `SRC_GROUND;
      gate_low_drive <= 1'b0;
      gate_high_drive <= 1'b0;
      porch_front_lines <= 9'd0;
      porch_back_lines <= 9'd0;
      line_clocks <= `LPERIOD_BASE;
      driven_lines <= `LINE_BASE;
      opamp_current_mult <= 5'd1;
      switch_order_sel <= 2'b00;
      resolution_sel <= 3'b000;
      band_first <= 10'd0;
      band_last <= 10'd0;
      band_off <= 1'b0;
      gamma_amp_on_time <= 8'h00;
      gamma_amp_off_time <= 8'h00;
      init_pulse <= 1'b0;
      display_enabled <= 1'b0;
      vsync_active <= 1'b0;
      hsync_active <= 1'b0;
      pixel_sample <= 1'b0;
      ext_unlocked <= 1'b0;
    end else begin
      source_mode <= p_srcgate[1:0];
      gate_low_drive <= p_srcgate[3];
      gate_high_drive <= p_srcgate[3] & p_srcgate[2];
      if (partial_idle) begin
        porch_front_lines <= {1'b0, p_fpi} + `PORCH_ADD;
        porch_back_lines <= {1'b0, p_bpi} + `PORCH_ADD;
        line_clocks <= `LPERIOD_BASE + {1'b0, p_lpi, 2'b00};
      end else begin
        porch_front_lines <= {1'b0, p_fp} + `PORCH_ADD;
        porch_back_lines <= {1'b0, p_bp} + `PORCH_ADD;
        line_clocks <= `LPERIOD_BASE + {1'b0, p_lp, 2'b00};
      end
      // line count only sets scan length, never memory addressing
      driven_lines <= `LINE_BASE + {1'b0, p_lines, 2'b00};
      opamp_current_mult <= {1'b0, p_op[7:4]} + 5'd1;
      switch_order_sel <= p_res[1:0];
      resolution_sel <= p_res[6:4];
      // band limits are 1-based numbers of the disabled centre channels
      case (p_res[6:4])
        3'b001: begin
          band_first <= 10'd385;
          band_last <= 10'd416;
          band_off <= 1'b1;
        end
        3'b010: begin
          band_first <= 10'd361;
          band_last <= 10'd440;
          band_off <= 1'b1;
        end
        3'b011: begin
          band_first <= 10'd301;
          band_last <= 10'd500;
          band_off <= 1'b1;
        end
        default: begin
          band_first <= 10'd0;
          band_last <= 10'd0;
          band_off <= 1'b0;
        end
      endcase
      gamma_amp_on_time <= pf[`PAR_GAMMA_AMP_ON_TIME*8 +: 8];
      gamma_amp_off_time <= pf[`PAR_GAMMA_AMP_OFF_TIME*8 +: 8];
      init_pulse <= init_run_reg;
      display_enabled <= (en2_reg == polarity_reg[0]);
      vsync_active <= (sync2_reg[0] == polarity_reg[1]);
      hsync_active <= (sync2_reg[1] == polarity_reg[2]);
      // edge taken behind the second flop so a metastable level never reaches it
      pixel_sample <= polarity_reg[3] ? (pclk_prev_reg & ~sync2_reg[2]) : (~pclk_prev_reg & sync2_reg[2]);
      ext_unlocked <= unlock_reg;
    end
  end
endmodule // display_setup

// *** sim/display_setup_sva.sv ***
// concurrent checks on the display setup block ports
// bound into display_setup; one clock, sync reset; init bounds assume INIT_STEP of 4
`timescale 1ns/10ps
`include "disp_setup_consts.vh"

module display_setup_sva #(
  parameter INIT_STEP = 4
) (
  input wire mclk,
  input wire reset,
  input wire cmd_valid,
  input wire cmd_is_param,
  input wire [7:0] cmd_byte,
  input wire [1:0] source_mode,
  input wire gate_low_drive,
  input wire gate_high_drive,
  input wire [10:0] line_clocks,
  input wire [10:0] driven_lines,
  input wire [2:0] resolution_sel,
  input wire [9:0] band_first,
  input wire [9:0] band_last,
  input wire init_pulse,
  input wire pixel_sample
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence op(logic [7:0] b);
    cmd_valid && !cmd_is_param && cmd_byte == b;
  endsequence
  a_disp_on_src: assert property (op(`CMD_DISPLAY_ON) |-> ##2 source_mode == `SRC_DISPLAY)
    else $error("display on did not select data drive");
  a_disp_off_src: assert property (op(`CMD_DISPLAY_OFF) |-> ##2 source_mode == `SRC_FULL_SCALE)
    else $error("display off did not select full scale");
  a_sleep_in_state: assert property (op(`CMD_SLEEP_IN) |-> ##2 source_mode == 2'h0 && gate_low_drive && !gate_high_drive)
    else $error("sleep in left wrong source or gate state");
  a_sleep_out_gate: assert property (op(`CMD_SLEEP_OUT) |-> ##2 gate_low_drive && gate_high_drive)
    else $error("sleep out did not enable full gate swing");
  a_soft_rst_src: assert property (op(`CMD_SOFT_RESET) |-> ##2 source_mode == 2'h0 && gate_low_drive && !gate_high_drive)
    else $error("software reset did not restore source and gate defaults");
  a_gate_swing_on: assert property (gate_high_drive |-> gate_low_drive)
    else $error("gate high drive without gate on");
  a_line_step: assert property (driven_lines[1:0] == 2'h0 && line_clocks[1:0] == 2'h0)
    else $error("line count or line clocks off the four step");
  a_band_720: assert property (resolution_sel == 3'h2 |-> band_first == 10'd361 && band_last == 10'd440)
    else $error("720 wide band limits wrong");
  a_init_min_len: assert property ($rose(init_pulse) |-> init_pulse [*4])
    else $error("init pulse shorter than one step");
  a_init_max_len: assert property ($rose(init_pulse) |-> ##[4:22] !init_pulse)
    else $error("init pulse longer than five steps");
  a_sample_single: assert property (pixel_sample |=> !pixel_sample)
    else $error("pixel sample longer than one cycle");
  c_disp_on: cover property (op(`CMD_DISPLAY_ON));
  c_sleep_in: cover property (op(`CMD_SLEEP_IN));
  c_init: cover property ($rose(init_pulse));
endmodule // display_setup_sva

bind display_setup display_setup_sva #(.INIT_STEP(INIT_STEP)) chk (.*);

// *** sim/host_model.sv ***
// host side: sends an opcode then its parameter bytes, one per cycle
// drives at falling mclk; bus shows inverted last byte once released
`timescale 1ns/10ps

module host_model (
  input wire mclk,
  output logic cmd_valid,
  output logic cmd_is_param,
  output logic [7:0] cmd_byte
);
  initial begin
    cmd_valid = 1'b0;
    cmd_is_param = 1'b0;
    cmd_byte = 8'h00;
  end

  task automatic send(input logic [7:0] opc, input logic [7:0] par[$]);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_is_param = 1'b0;
    cmd_byte = opc;
    foreach (par[i]) begin
      @(negedge mclk);
      cmd_is_param = 1'b1;
      cmd_byte = par[i];
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_byte = ~cmd_byte;
  endtask
endmodule // host_model

// *** sim/tb_top.sv ***
// self-checking bench for the display setup block
// host model sends commands; pixel pins and mode inputs driven here at falling mclk
`timescale 1ns/10ps
`include "disp_setup_consts.vh"

module tb_top;
  logic mclk = 1'b0, reset = 1'b1, partial_idle = 1'b0, init_start = 1'b0;
  logic pixel_clock_in = 1'b0, vertical_sync_in = 1'b1, horizontal_sync_in = 1'b1, enable_in = 1'b0;
  wire cmd_valid, cmd_is_param, gate_low_drive, gate_high_drive, band_off, init_pulse;
  wire display_enabled, vsync_active, hsync_active, pixel_sample, ext_unlocked;
  wire [7:0] cmd_byte, gamma_amp_on_time, gamma_amp_off_time;
  wire [1:0] source_mode, switch_order_sel;
  wire [8:0] porch_front_lines, porch_back_lines;
  wire [10:0] line_clocks, driven_lines;
  wire [4:0] opamp_current_mult;
  wire [2:0] resolution_sel;
  wire [9:0] band_first, band_last;
  int miscompares = 0, comparisons = 0, n, len;
  logic [7:0] p[12];
  logic [7:0] q[$];
  logic [3:0] pol;
  logic [7:0] dflt[12] = '{8'h08, 8'hc8, 8'h00, 8'h00, 8'h05, 8'h70, 8'h00, 8'hff, 8'h00, 8'h00, 8'h05, 8'h20};
  logic [7:0] auto_op[4] = '{`CMD_SLEEP_IN, `CMD_SLEEP_OUT, `CMD_DISPLAY_ON, `CMD_DISPLAY_OFF};
  logic [3:0] auto_exp[4] = '{4'h2, 4'h3, 4'hf, 4'hb};

  always #12.5 mclk = ~mclk;

  host_model host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_is_param(cmd_is_param), .cmd_byte(cmd_byte));
  display_setup #(.INIT_STEP(4)) dut (.*);

  task end_of_test();
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [20:0] e, input logic [20:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task wt(input int c);
    repeat (c) @(negedge mclk);
  endtask

  function automatic logic [19:0] exp_band(input logic [2:0] r);
    case (r)
      3'h1: return {10'd385, 10'd416};
      3'h2: return {10'd361, 10'd440};
      3'h3: return {10'd301, 10'd500};
      default: return 20'h0;
    endcase
  endfunction

  // legal random byte per field, with table limits on the first pass
  function automatic logic [7:0] rnd(input int k, input int i);
    case (k)
      0: return {4'h0, 2'($urandom), 2'($urandom_range(3, 2))};
      1: return i == 0 ? `NL_MAX : 8'($urandom_range(222));
      2, 3, 8, 9: return i == 0 ? 8'hff : i == 1 ? 8'h01 : 8'($urandom_range(255, 1));
      5: return i == 0 ? 8'hf4 : {4'($urandom), 1'b0, 3'($urandom_range(4))};
      11: return {1'b0, 3'($urandom_range(3)), 2'h0, 2'($urandom)};
      default: return 8'($urandom);
    endcase
  endfunction

  task check_setup();
    logic [7:0] bp, fp, rt;
    bp = partial_idle ? p[8] : p[2];
    fp = partial_idle ? p[9] : p[3];
    rt = partial_idle ? p[10] : p[4];
    chk("src", p[0][1:0], source_mode);
    chk("gate", {p[0][3], p[0][3] & p[0][2]}, {gate_low_drive, gate_high_drive});
    chk("lines", 11'd480 + 4 * p[1], driven_lines);
    chk("bporch", bp + 11'd2, porch_back_lines);
    chk("fporch", fp + 11'd2, porch_front_lines);
    chk("lclk", 11'd600 + 4 * rt, line_clocks);
    chk("opamp", p[5][7:4] + 11'd1, opamp_current_mult);
    chk("gamma", {p[6], p[7]}, {gamma_amp_on_time, gamma_amp_off_time});
    chk("tgs", p[11][1:0], switch_order_sel);
    chk("res", p[11][6:4], resolution_sel);
    chk("band", {p[11][6:4] != 3'h0, exp_band(p[11][6:4])}, {band_off, band_first, band_last});
  endtask

  initial begin
    void'($urandom(32'h7103));
    wt(10);
    reset = 1'b0;
    wt(3);
    p = dflt;
    check_setup();
    q = '{8'h0b, 8'h00};
    host.send(`CMD_DISPLAY_SETUP, q);
    wt(3);
    check_setup();
    chk("unlock", 0, ext_unlocked);
    q = '{`UNLOCK_KEY0, `UNLOCK_KEY1, `UNLOCK_KEY2};
    host.send(`CMD_EXT_UNLOCK, q);
    wt(3);
    chk("unlock", 1, ext_unlocked);
    for (int i = 0; i < 6; i++) begin
      partial_idle = 1'($urandom);
      q = {};
      n = (i == 5) ? 2 : 12;
      for (int k = 0; k < n; k++) begin
        p[k] = rnd(k, i);
        q.push_back(p[k]);
      end
      host.send(`CMD_DISPLAY_SETUP, q);
      wt(3);
      check_setup();
      init_start = 1'b1;
      len = 0;
      repeat (30) begin
        @(negedge mclk);
        init_start = 1'b0;
        len += init_pulse;
      end
      n = (p[5][2:0] + 1) * 4;
      chk("init_len", 1, len >= n - 1 && len <= n + 2);
    end
    q = {};
    foreach (auto_op[j]) begin
      host.send(auto_op[j], q);
      wt(3);
      chk("auto", auto_exp[j], {source_mode, gate_low_drive, gate_high_drive});
    end
    for (int i = 0; i < 16; i++) begin
      pol = 4'(i);
      q = '{{4'h0, pol}};
      host.send(`CMD_PIXEL_IF_POL, q);
      enable_in = 1'($urandom);
      vertical_sync_in = 1'($urandom);
      horizontal_sync_in = 1'($urandom);
      wt(5);
      chk("enable", enable_in == pol[0], display_enabled);
      chk("vsync", vertical_sync_in == pol[1], vsync_active);
      chk("hsync", horizontal_sync_in == pol[2], hsync_active);
      pixel_clock_in = ~pixel_clock_in;
      n = 0;
      repeat (6) @(negedge mclk) n += pixel_sample;
      chk("sample", pixel_clock_in ^ pol[3], 21'(n));
    end
    q = {};
    host.send(`CMD_SOFT_RESET, q);
    wt(3);
    p = dflt;
    check_setup();
    chk("pol_rst", enable_in, display_enabled);
    end_of_test();
  end

  initial begin
    #(20000 * 25);
    miscompares++;
    end_of_test();
  end
endmodule // tb_top
